// file: gst_far_side.sv
// far side model: count pin pulse source and gate pin driver
`timescale 1ns/1ps
module gst_far_side (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] pulses_i,
  input wire logic gate_lvl_i,
  output logic ext_clk_o,
  output logic gate_o,
  output logic busy_o
);
  localparam int HALF = 4;
  int left = 0;
  int ph = 0;
  initial begin
    ext_clk_o = 1'b0;
    gate_o = 1'b0;
    busy_o = 1'b0;
  end
  // burst of pulses, pin stands low between bursts
  always @(posedge clk_i) begin
    gate_o <= gate_lvl_i;
    if (go_i) begin
      left = pulses_i;
      ph = 0;
    end else if (left > 0) begin
      ph = ph + 1;
      if (ph == HALF) ext_clk_o <= 1'b1;
      if (ph == 2 * HALF) begin
        ext_clk_o <= 1'b0;
        ph = 0;
        left = left - 1;
      end
    end
    busy_o <= go_i || left > 0;
  end
endmodule

// file: gst_pkg.sv
// constants for the gated sixteen bit timer
package gst_pkg;
  // register addresses
  localparam logic [7:0] GST_ADDR_COUNT_LOW = 8'h0E;
  localparam logic [7:0] GST_ADDR_COUNT_HIGH = 8'h0F;
  localparam logic [7:0] GST_ADDR_CONTROL = 8'h10;
  localparam logic [7:0] GST_ADDR_IRQ = 8'h11;
  localparam logic [7:0] GST_ADDR_CAPTURE_LOW = 8'h12;
  localparam logic [7:0] GST_ADDR_CAPTURE_HIGH = 8'h13;
  localparam logic [7:0] GST_ADDR_COMPARE_LOW = 8'h14;
  localparam logic [7:0] GST_ADDR_COMPARE_HIGH = 8'h15;
  // control register field positions
  localparam int GST_BIT_TIMER_ON = 0;
  localparam int GST_BIT_CLOCK_SOURCE = 1;
  localparam int GST_BIT_SYNC_DISABLE = 2;
  localparam int GST_BIT_OSC_ENABLE = 3;
  localparam int GST_BIT_PRESCALE_LO = 4;
  localparam int GST_BIT_GATE_ENABLE = 6;
  localparam int GST_BIT_GATE_POLARITY = 7;
  // irq register field positions
  localparam int GST_BIT_FLAG = 0;
  localparam int GST_BIT_OVF_IE = 1;
  localparam int GST_BIT_PERIPH_IE = 2;
  localparam int GST_BIT_GLOBAL_IE = 3;
  // reset values and the count maximum
  localparam logic [7:0] GST_CONTROL_RESET = 8'h00;
  localparam logic [15:0] GST_COUNT_RESET = 16'h0000;
  localparam logic [15:0] GST_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] GST_COMPARE_RESET = 16'hFFFF;
  localparam logic [2:0] GST_PRESCALE_RESET = 3'h0;
  localparam logic [7:0] GST_READ_IDLE = 8'h00;
  // one full prescaler cycle in counting clock ticks minus one
  localparam logic [2:0] GST_LIMIT_DIV1 = 3'h0;
  localparam logic [2:0] GST_LIMIT_DIV2 = 3'h1;
  localparam logic [2:0] GST_LIMIT_DIV4 = 3'h3;
  localparam logic [2:0] GST_LIMIT_DIV8 = 3'h7;
endpackage

// file: gst_timer.sv
// gated sixteen bit timer with prescaler, gate and special clear
//
// What this block does
// RQ1 - sixteen bit up counter as two bytes; byte writes replace the live count
// RQ2 - source select 0 counts system clock, 1 counts pin or oscillator
// RQ3 - external source advances on each rising edge after the prescaler
// RQ4 - sync disable only lets external counting run in sleep; the pin is always synchronised
// RQ5 - one falling edge needed after enable or count write before counting
// RQ6 - two bit prescale field divides by 1, 2, 4 or 8
// RQ7 - prescaler hidden from software and cleared on any count byte write
// RQ8 - oscillator enable starts the 32.768 kHz oscillator, pins go analog
// RQ9 - software waits for oscillator start-up before enabling the timer
// RQ10 - only asynchronous external mode counts in sleep and wakes on overflow
// RQ11 - each single byte read returns a valid value
// RQ12 - software should stop the timer before writing in async mode
// RQ13 - gate enable makes counting follow the gate pin while timer on
// RQ14 - gate polarity set means active high, clear means active low
// RQ15 - past FFFF the count wraps to 0000 and sets the overflow flag
// RQ16 - interrupt needs all three enables; software clears the flag
// RQ17 - wake needs timer on plus both enables; global enable picks vector
// RQ18 - capture event copies the count into the capture pair
// RQ19 - compare event when count equals the compare pair
// RQ20 - special event clears the count without setting the overflow flag
// RQ21 - count write in the same cycle as special clear wins
// RQ22 - special clear should be used with synchronised counting
// RQ23 - mode switches may lose or add one increment
// RQ24 - timer off holds the count and raises no overflow
// RQ25 - overflow flag set on every overflow whatever the enables
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module gst_timer
  import gst_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [7:0] rdata_o,
  input wire logic external_count_input_i,
  input wire logic osc_clk_i,
  input wire logic gate_input_pin_i,
  input wire logic sleep_i,
  input wire logic capture_event_i,
  input wire logic special_event_i,
  output logic low_power_osc_enable_o,
  output logic osc_pins_analog_o,
  output logic compare_match_o,
  output logic irq_request_o,
  output logic wake_o,
  output logic wake_vector_o
);

  typedef struct packed {
    logic [15:0] count;
    logic [2:0] presc;
    logic armed;
    logic ext_s1;
    logic ext_s2;
    logic osc_s1;
    logic osc_s2;
    logic ext_prev;
    logic gate_s1;
    logic gate_s2;
    logic on_prev;
    logic [7:0] ctrl;
    logic flag;
    logic ovf_ie;
    logic periph_ie;
    logic global_ie;
    logic [15:0] compare;
    logic [15:0] capture;
    logic match;
    logic [7:0] rdata;
  } gst_state_s;

  gst_state_s r;
  gst_state_s next_r;

  // prescaler end count for a ratio select
  function automatic logic [2:0] gst_limit(input logic [1:0] sel);
    case (sel)
      2'h0: gst_limit = GST_LIMIT_DIV1;
      2'h1: gst_limit = GST_LIMIT_DIV2;
      2'h2: gst_limit = GST_LIMIT_DIV4;
      default: gst_limit = GST_LIMIT_DIV8;
    endcase
  endfunction

  // true when a bus write hits the given address
  function automatic logic gst_wr(input logic we, input logic [7:0] a,
                                  input logic [7:0] hit);
    gst_wr = we && (a == hit);
  endfunction

  logic timer_on;
  logic src_ext;
  logic no_sync;
  logic gate_active;
  logic count_ok;
  logic sleep_block;
  logic tick;
  logic inc;
  logic wr_low;
  logic wr_high;
  logic wr_count;
  logic pin_mux;

  // decoded control bits and counting conditions
  assign timer_on = r.ctrl[GST_BIT_TIMER_ON];
  assign src_ext = r.ctrl[GST_BIT_CLOCK_SOURCE];
  assign no_sync = r.ctrl[GST_BIT_SYNC_DISABLE];
  // pick the synchronised oscillator or count pin level
  assign pin_mux = r.ctrl[GST_BIT_OSC_ENABLE] ? r.osc_s2 : r.ext_s2;
  // gate level after polarity select [RQ14]
  assign gate_active = r.ctrl[GST_BIT_GATE_POLARITY] ? r.gate_s2
                                                     : !r.gate_s2;
  // gate only matters while the timer is on [RQ13] [RQ24]
  assign count_ok = timer_on &&
                    (!r.ctrl[GST_BIT_GATE_ENABLE] || gate_active);
  // sleep stops all but unsynchronised external counting [RQ10]
  assign sleep_block = sleep_i && !(src_ext && no_sync);
  // system clock ticks every cycle, pin ticks on armed rising edge
  // the sync disable bit only changes sleep behaviour here, so a mode
  // switch may drop or add one increment [RQ2] [RQ3] [RQ4] [RQ23]
  assign tick = src_ext ? (pin_mux && !r.ext_prev && r.armed) : 1'b1;
  // counter steps when the prescaler completes a cycle [RQ6]
  assign inc = tick && count_ok && !sleep_block &&
               (r.presc == gst_limit(r.ctrl[GST_BIT_PRESCALE_LO +: 2]));
  assign wr_low = gst_wr(write_i, addr_i, GST_ADDR_COUNT_LOW);
  assign wr_high = gst_wr(write_i, addr_i, GST_ADDR_COUNT_HIGH);
  assign wr_count = wr_low || wr_high;

  // next state of the whole block
  always_comb begin
    next_r = r;
    // two flops on each pin before any logic reads it
    next_r.ext_s1 = external_count_input_i;
    next_r.ext_s2 = r.ext_s1;
    next_r.osc_s1 = osc_clk_i;
    next_r.osc_s2 = r.osc_s1;
    next_r.ext_prev = pin_mux;
    next_r.gate_s1 = gate_input_pin_i;
    next_r.gate_s2 = r.gate_s1;
    next_r.on_prev = timer_on;
    next_r.match = 1'b0;
    // falling edge arms the first rising edge [RQ5]
    if (r.ext_prev && !pin_mux) begin
      next_r.armed = 1'b1;
    end
    if (timer_on && !r.on_prev) begin
      next_r.armed = 1'b0; // [RQ5]
    end
    // prescaler advances on qualified ticks
    if (tick && count_ok && !sleep_block) begin
      if (inc) begin
        next_r.presc = GST_PRESCALE_RESET;
      end else begin
        next_r.presc = r.presc + 3'h1;
      end
    end
    // count update: write beats special clear beats increment
    if (wr_count) begin
      if (wr_low) begin
        next_r.count[7:0] = wdata_i; // [RQ1]
      end else begin
        next_r.count[15:8] = wdata_i; // [RQ1]
      end
      next_r.presc = GST_PRESCALE_RESET; // [RQ7]
      next_r.armed = 1'b0; // [RQ5]
    end else if (special_event_i) begin
      next_r.count = GST_COUNT_RESET; // [RQ20] [RQ21]
    end else if (inc) begin
      next_r.count = r.count + 16'h0001; // [RQ15]
      if (r.count + 16'h0001 == r.compare) begin
        next_r.match = 1'b1; // [RQ19]
      end
    end
    // capture copies the live count [RQ18]
    if (capture_event_i) begin
      next_r.capture = r.count;
    end
    // register writes
    if (gst_wr(write_i, addr_i, GST_ADDR_CONTROL)) begin
      next_r.ctrl = wdata_i; // [RQ8]
    end
    if (gst_wr(write_i, addr_i, GST_ADDR_IRQ)) begin
      next_r.flag = r.flag && wdata_i[GST_BIT_FLAG]; // [RQ16]
      next_r.ovf_ie = wdata_i[GST_BIT_OVF_IE];
      next_r.periph_ie = wdata_i[GST_BIT_PERIPH_IE];
      next_r.global_ie = wdata_i[GST_BIT_GLOBAL_IE];
    end
    if (gst_wr(write_i, addr_i, GST_ADDR_COMPARE_LOW)) begin
      next_r.compare[7:0] = wdata_i;
    end
    if (gst_wr(write_i, addr_i, GST_ADDR_COMPARE_HIGH)) begin
      next_r.compare[15:8] = wdata_i;
    end
    // overflow sets the flag whatever the enables, set wins over clear
    if (!wr_count && !special_event_i && inc &&
        r.count == GST_COUNT_MAX) begin
      next_r.flag = 1'b1; // [RQ15] [RQ25]
    end
    // read data from a single clocked snapshot, so one byte is whole
    next_r.rdata = GST_READ_IDLE;
    if (read_i) begin
      case (addr_i)
        GST_ADDR_COUNT_LOW: next_r.rdata = r.count[7:0]; // [RQ11]
        GST_ADDR_COUNT_HIGH: next_r.rdata = r.count[15:8]; // [RQ11]
        GST_ADDR_CONTROL: next_r.rdata = r.ctrl;
        GST_ADDR_IRQ: next_r.rdata = {4'h0, r.global_ie, r.periph_ie,
                                      r.ovf_ie, r.flag};
        GST_ADDR_CAPTURE_LOW: next_r.rdata = r.capture[7:0];
        GST_ADDR_CAPTURE_HIGH: next_r.rdata = r.capture[15:8];
        GST_ADDR_COMPARE_LOW: next_r.rdata = r.compare[7:0];
        GST_ADDR_COMPARE_HIGH: next_r.rdata = r.compare[15:8];
        default: next_r.rdata = GST_READ_IDLE;
      endcase
    end
  end

  // state register with clock enable
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.ctrl <= GST_CONTROL_RESET;
      r.count <= GST_COUNT_RESET;
      r.compare <= GST_COMPARE_RESET;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // outputs
  assign rdata_o = r.rdata;
  assign compare_match_o = r.match;
  assign low_power_osc_enable_o = r.ctrl[GST_BIT_OSC_ENABLE]; // [RQ8]
  assign osc_pins_analog_o = r.ctrl[GST_BIT_OSC_ENABLE]; // [RQ8]
  // interrupt needs flag and all three enables [RQ16]
  assign irq_request_o = r.flag && r.ovf_ie && r.periph_ie && r.global_ie;
  // wake needs timer on and two enables, global picks vector [RQ17]
  assign wake_o = r.flag && timer_on && r.ovf_ie && r.periph_ie;
  assign wake_vector_o = wake_o && r.global_ie; // [RQ17]

  default clocking gst_cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // checks next to the logic
  a_write_low_byte: assert property ( // [RQ1]
    ce_i && wr_low |=> r.count[7:0] == $past(wdata_i))
    else $error("count low byte write not applied");
  a_prescale_clear: assert property ( // [RQ7]
    ce_i && wr_count |=> r.presc == GST_PRESCALE_RESET && !r.armed)
    else $error("count write did not clear prescaler or arm");
  a_hold_when_off: assert property ( // [RQ24]
    ce_i && !timer_on && !write_i && !special_event_i
    |=> $stable(r.count) && !($rose(r.flag)))
    else $error("count moved while timer off");
  a_wrap_sets_flag: assert property ( // [RQ15]
    ce_i && inc && r.count == GST_COUNT_MAX && !wr_count &&
    !special_event_i |=> r.count == GST_COUNT_RESET && r.flag)
    else $error("wrap did not clear count and set flag");
  a_special_clear: assert property ( // [RQ20]
    ce_i && special_event_i && !wr_count && !r.flag
    |=> r.count == GST_COUNT_RESET && !r.flag)
    else $error("special clear wrong");
  a_write_beats_clear: assert property ( // [RQ21]
    ce_i && special_event_i && wr_high
    |=> r.count[15:8] == $past(wdata_i) &&
        r.count[7:0] == $past(r.count[7:0]))
    else $error("special clear beat a count write");
  a_irq_gating: assert property ( // [RQ16]
    irq_request_o |-> r.flag && r.ovf_ie && r.periph_ie && r.global_ie)
    else $error("interrupt raised without all enables");
  a_gate_blocks: assert property ( // [RQ13]
    ce_i && timer_on && r.ctrl[GST_BIT_GATE_ENABLE] && !gate_active &&
    !write_i && !special_event_i |=> $stable(r.count))
    else $error("count moved with gate closed");
  a_capture_copy: assert property ( // [RQ18]
    ce_i && capture_event_i |=> r.capture == $past(r.count))
    else $error("capture pair not loaded");
  a_compare_pulse: assert property ( // [RQ19]
    $rose(compare_match_o) |-> r.count == r.compare && $changed(r.count))
    else $error("compare pulse without match");
  a_sleep_hold: assert property ( // [RQ10]
    ce_i && sleep_i && !src_ext && !write_i && !special_event_i
    |=> $stable(r.count))
    else $error("synchronous count moved in sleep");

  // extra checks on bytes, arming and counting
  a_write_high_byte: assert property ( // [RQ1]
    ce_i && wr_high |=> r.count[15:8] == $past(wdata_i))
    else $error("count high byte write not applied");

  // first pin edge needs arming
  a_arm_on_enable: assert property ( // [RQ5]
    ce_i && timer_on && !r.on_prev |=> !r.armed)
    else $error("enable did not clear arming");
  a_no_tick_unarmed: assert property ( // [RQ5]
    ce_i && src_ext && !r.armed && !write_i && !special_event_i
    |=> $stable(r.count))
    else $error("pin counted before a falling edge");
  a_step_by_one: assert property ( // [RQ15]
    ce_i && inc && !wr_count && !special_event_i
    |=> r.count == $past(r.count) + 16'h0001)
    else $error("increment did not step by one");
  a_match_on_inc: assert property ( // [RQ19]
    ce_i && inc && !wr_count && !special_event_i &&
    r.count + 16'h0001 == r.compare |=> compare_match_o)
    else $error("compare match missed");

  // flag and wake outputs
  a_flag_sticky: assert property ( // [RQ16]
    ce_i && r.flag && !(write_i && addr_i == GST_ADDR_IRQ)
    |=> r.flag)
    else $error("overflow flag lost without a clear");
  a_wake_gating: assert property ( // [RQ17]
    wake_o |-> r.flag && timer_on && r.ovf_ie && r.periph_ie)
    else $error("wake raised without enables");
  a_vector_gating: assert property ( // [RQ17]
    wake_vector_o |-> wake_o && r.global_ie)
    else $error("vector wake without global enable");

  // read port and capture hold
  a_read_idle: assert property ( // [RQ11]
    ce_i && !read_i |=> rdata_o == GST_READ_IDLE)
    else $error("read data not idle");
  a_read_count_low: assert property ( // [RQ11]
    ce_i && read_i && addr_i == GST_ADDR_COUNT_LOW
    |=> rdata_o == $past(r.count[7:0]))
    else $error("count low byte read wrong");
  a_capture_hold: assert property ( // [RQ18]
    ce_i && !capture_event_i |=> $stable(r.capture))
    else $error("capture pair moved without event");

  // clock enable freeze
  a_ce_freeze: assert property ( // [RQ24]
    !ce_i |=> $stable(r.count) && $stable(r.ctrl))
    else $error("state moved with clock enable low");

endmodule

// file: gst_timer_test.sv
// self-checking bench for the gated sixteen bit timer
`timescale 1ns/1ps
module gst_timer_test;
  import gst_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1;
  logic write_i = 1'b0, read_i = 1'b0, sleep_i = 1'b0, go = 1'b0;
  logic capture_event_i = 1'b0, special_event_i = 1'b0, gate_lvl = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, pulses = 8'h05;
  logic [7:0] rdata_o, v, lo, hi;
  logic ext, gate_pin, busy, osc_en, osc_an, cmp_m, irq, wake, wvec;
  logic osc = 1'b0;
  int err_count = 0, n_tests = 0, cmp_seen = 0, seed = 32'h94C0;
  int cnt, k, n;
  gst_timer DUT (.clk_i, .reset_i, .ce_i, .addr_i, .wdata_i, .write_i,
    .read_i, .rdata_o, .external_count_input_i(ext), .osc_clk_i(osc),
    .gate_input_pin_i(gate_pin), .sleep_i, .capture_event_i,
    .special_event_i, .low_power_osc_enable_o(osc_en),
    .osc_pins_analog_o(osc_an), .compare_match_o(cmp_m),
    .irq_request_o(irq), .wake_o(wake), .wake_vector_o(wvec));
  gst_far_side FAR (.clk_i, .go_i(go), .pulses_i(pulses),
    .gate_lvl_i(gate_lvl), .ext_clk_o(ext), .gate_o(gate_pin),
    .busy_o(busy));
  initial forever #12.5 clk_i = ~clk_i;
  // counts compare pulses seen
  always @(negedge clk_i) if (cmp_m === 1'b1) cmp_seen++;
  task check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask
  task cnt_is(input logic [15:0] e);
    rd(GST_ADDR_COUNT_LOW, lo);
    rd(GST_ADDR_COUNT_HIGH, hi);
    check("count", e, {hi, lo});
  endtask
  // timer on for k edges, then off with other bits kept
  task run(input logic [7:0] ctl, input int m);
    wr(GST_ADDR_CONTROL, ctl);
    repeat (m) @(posedge clk_i);
    wr(GST_ADDR_CONTROL, ctl & 8'hFE);
    k = m + 2;
  endtask
  task results;
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    results;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(GST_ADDR_CONTROL, v);
    check("control", 16'h0000, {8'h00, v});
    cnt_is(16'h0000);
    // every prescale ratio from a random start
    for (int ps = 0; ps < 4; ps++) begin
      cnt = $random(seed);
      n = 8 + ($random(seed) & 31);
      wr16(GST_ADDR_COUNT_LOW, cnt[15:0]);
      run({2'h0, 2'(ps), 4'h1}, n);
      cnt_is(16'(cnt + k / (1 << ps)));
    end
    // wrap with all enables, then wake without global enable
    wr(GST_ADDR_IRQ, 8'h0E);
    wr16(GST_ADDR_COUNT_LOW, 16'hFFFD);
    run(8'h01, 4);
    #1 check("irq wake", 16'h0004, {13'h0, irq, wake, wvec});
    cnt_is(16'h0003);
    rd(GST_ADDR_IRQ, v);
    check("irq reg", 16'h000F, {8'h00, v});
    wr(GST_ADDR_IRQ, 8'h07);
    wr(GST_ADDR_CONTROL, 8'h01);
    #1 check("irq wake", 16'h0002, {13'h0, irq, wake, wvec});
    wr(GST_ADDR_CONTROL, 8'h00);
    wr(GST_ADDR_IRQ, 8'h00);
    rd(GST_ADDR_IRQ, v);
    check("irq reg", 16'h0000, {8'h00, v});
    // both gate polarities against both pin levels
    for (int g = 0; g < 4; g++) begin
      gate_lvl <= g[0];
      wr16(GST_ADDR_COUNT_LOW, 16'h0100);
      run({g[1], 7'h41}, 6);
      cnt_is(16'(256 + (g[0] == g[1] ? k : 0)));
    end
    sleep_i <= 1'b1;
    wr16(GST_ADDR_COUNT_LOW, 16'h0200);
    run(8'h01, 6);
    cnt_is(16'h0200);
    // pin counting awake synchronised, asleep unsynchronised, then from
    // the still oscillator; count written with the timer off
    for (int m = 0; m < 3; m++) begin
      sleep_i <= m[0];
      wr16(GST_ADDR_COUNT_LOW, 16'h0000);
      wr(GST_ADDR_CONTROL, m[1] ? 8'h0B : (m[0] ? 8'h07 : 8'h03));
      @(posedge clk_i);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      #1;
      for (int t = 0; t < 100 && busy; t++) @(posedge clk_i);
      repeat (10) @(posedge clk_i);
      wr(GST_ADDR_CONTROL, 8'h02);
      cnt_is(m[1] ? 16'h0000 : 16'h0004);
    end
    sleep_i <= 1'b0;
    wr16(GST_ADDR_COUNT_LOW, 16'h1234);
    @(posedge clk_i);
    capture_event_i <= 1'b1;
    @(posedge clk_i);
    capture_event_i <= 1'b0;
    rd(GST_ADDR_CAPTURE_LOW, lo);
    rd(GST_ADDR_CAPTURE_HIGH, hi);
    check("capture", 16'h1234, {hi, lo});
    // special clear alone, then beside a byte write, synchronised
    @(posedge clk_i);
    special_event_i <= 1'b1;
    @(posedge clk_i);
    special_event_i <= 1'b0;
    cnt_is(16'h0000);
    rd(GST_ADDR_IRQ, v);
    check("irq reg", 16'h0000, {8'h00, v});
    @(posedge clk_i);
    addr_i <= GST_ADDR_COUNT_LOW;
    wdata_i <= 8'h55;
    write_i <= 1'b1;
    special_event_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
    special_event_i <= 1'b0;
    cnt_is(16'h0055);
    wr16(GST_ADDR_COMPARE_LOW, 16'h0005);
    wr16(GST_ADDR_COUNT_LOW, 16'h0000);
    cmp_seen = 0;
    run(8'h01, 10);
    cnt_is(16'(k));
    check("compare", 16'h0001, 16'(cmp_seen));
    // clock enable low freezes count and register writes
    wr16(GST_ADDR_COUNT_LOW, 16'h0300);
    ce_i <= 1'b0;
    wr(GST_ADDR_CONTROL, 8'h01);
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b1;
    cnt_is(16'h0300);
    rd(GST_ADDR_CONTROL, v);
    check("frozen control", 16'h0000, {8'h00, v});
    wr(GST_ADDR_CONTROL, 8'h08);
    #1 check("osc", 16'h0003, {14'h0, osc_en, osc_an});
    // oscillator start-up wait, then oscillator off and an unmapped address read
    repeat (20) @(posedge clk_i);
    wr(GST_ADDR_CONTROL, 8'h00);
    rd(8'h20, v);
    check("unmapped", 16'h0000, {8'h00, v});
    results;
  end
endmodule
